/* File: logic/board_support_oversight.sv */
// Purpose: Board support logic for a trigger merger card
// Assumes: All inputs synchronous to clk_in; APB master outside
// Notes: Zero wait APB slave, read data registered in the setup phase
// Overview of operation
// - Divide own clock by two to clock the configuration controller.
// - Controller port accesses change only in step with that divided clock.
// - Keep bus buffers disabled until this logic is up and running.
// - Drive the acknowledge only when this logic is up and a card cycle is present.
// - Hold port transceivers off until the enable confirmation is given.
// - After release, follow the owning FPGA's direction and enable requests.
// - Switch all transceivers of a port together, with an off gap.
// - Drive 3 green and 6 bicolour LEDs from FPGA LED requests and the LED register.
// - After power is stable, request the default configuration load.
// - Software selects a file and commands a (re)configuration.
// - Merge backplane and jumper address bits and deliver them to all.
// - Own decoder lines; base gets reset and accept, top gets all.
// - Sense presence and configuration of each FPGA for the enable.
// - Bus registers control and monitor controller, decoder and optics.
//
// Design decisions made here: the register addresses and the APB register port.
module board_support_oversight
	import board_support_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic power_good_in,
	output logic cfg_clk_out,
	output logic cfg_auto_load_out,
	output logic [board_support_pkg::FILE_W-1:0] cfg_file_sel_out,
	output logic cfg_reconfig_out,
	output logic [board_support_pkg::MPU_AW-1:0] mpu_addr_out,
	input wire logic [board_support_pkg::MPU_DW-1:0] mpu_data_in,
	output logic [board_support_pkg::MPU_DW-1:0] mpu_data_out,
	output logic mpu_data_oe_n_out,
	output logic mpu_cs_n_out,
	output logic mpu_we_n_out,
	output logic mpu_oe_n_out,
	input wire logic vme_select_in,
	output logic vme_buf_en_n_out,
	output logic dtack_out,
	output logic dtack_oe_n_out,
	input wire logic base_present_in,
	input wire logic base_done_in,
	input wire logic top_present_in,
	input wire logic top_done_in,
	output logic enable_out,
	input wire logic [board_support_pkg::NPORTS-1:0] base_port_want_in,
	input wire logic [board_support_pkg::NPORTS-1:0] base_port_dir_in,
	input wire logic [board_support_pkg::NPORTS-1:0] top_port_want_in,
	input wire logic [board_support_pkg::NPORTS-1:0] top_port_dir_in,
	output logic [board_support_pkg::NPORTS-1:0] port_dir_out,
	output logic [board_support_pkg::NPORTS-1:0] port_oe_n_out,
	input wire logic [board_support_pkg::LED_REQ_W-1:0] base_led_req_in,
	input wire logic [board_support_pkg::LED_REQ_W-1:0] top_led_req_in,
	output logic [board_support_pkg::LED_GREEN_N-1:0] led_green_out,
	output logic [board_support_pkg::LED_BI_N-1:0] led_bi_green_out,
	output logic [board_support_pkg::LED_BI_N-1:0] led_bi_red_out,
	input wire logic [3:0] ga_backplane_in,
	input wire logic [2:0] ga_jumper_in,
	output logic [board_support_pkg::GA_W-1:0] ga_out,
	input wire logic bunch_reset_in,
	input wire logic level1_accept_in,
	input wire logic [board_support_pkg::DEC_W-1:0] decoder_data_in,
	input wire logic [board_support_pkg::CTRL_W-1:0] decoder_status_in,
	output logic [board_support_pkg::CTRL_W-1:0] decoder_ctrl_out,
	output logic base_bunch_reset_out,
	output logic base_level1_accept_out,
	output logic top_bunch_reset_out,
	output logic top_level1_accept_out,
	output logic [board_support_pkg::DEC_W-1:0] top_decoder_data_out,
	input wire logic [board_support_pkg::CTRL_W-1:0] optical_status_in,
	output logic [board_support_pkg::CTRL_W-1:0] optical_ctrl_out
);
	import board_support_pkg::*;

	typedef enum logic [1:0] {MPU_IDLE, MPU_SETUP, MPU_STROBE, MPU_HOLD} mpu_state_t;

	localparam int LED_N = LED_GREEN_N + 2 * LED_BI_N;

	typedef struct packed {
		logic phase;
		logic ready;
		logic [31:0] prdata;
		logic slverr;
		logic release_ok;
		logic led_sw;
		logic [NPORTS-1:0] owner_top;
		logic [LED_N-1:0] led_reg;
		logic [LED_N-1:0] leds;
		logic [FILE_W-1:0] file_sel;
		logic [RECFG_CW-1:0] recfg_cnt;
		logic auto_load;
		mpu_state_t mpu_state;
		logic mpu_go;
		logic [MPU_AW-1:0] mpu_addr;
		logic [MPU_DW-1:0] mpu_wdata;
		logic mpu_write;
		logic [MPU_DW-1:0] mpu_rdata;
		logic [MPU_AW-1:0] port_addr;
		logic [MPU_DW-1:0] port_wdata;
		logic [CTRL_W-1:0] dec_ctrl;
		logic [CTRL_W-1:0] opt_ctrl;
		logic [GA_W-1:0] ga;
		logic [1:0] base_tim;
		logic [1:0] top_tim;
		logic [DEC_W-1:0] top_data;
		logic enable;
		logic buf_en;
		logic dtack_on;
	} state_t;

	state_t st;
	state_t next_st;
	logic setup_ph;
	logic access_ph;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [LED_N-1:0] led_req;
	logic mpu_busy;

	// Status word seen by software
	always_comb
	begin
		status_word = '0;
		status_word[ST_BASE_PRES] = base_present_in;
		status_word[ST_BASE_DONE] = base_done_in;
		status_word[ST_TOP_PRES] = top_present_in;
		status_word[ST_TOP_DONE] = top_done_in;
		status_word[ST_ENABLE] = st.enable;
		status_word[ST_POWER] = power_good_in;
		status_word[ST_MPU_BUSY] = mpu_busy;
		status_word[ST_RECFG_BUSY] = (st.recfg_cnt != '0);
		status_word[ST_GA_LSB +: GA_W] = st.ga;
	end

	// Read data, decoded while the setup cycle stands
	always_comb
	begin
		rd_mux = '0;
		rd_hit = 1'b1;
		unique case (paddr_in)
			OFS_CTRL:
			begin
				rd_mux[CTRL_RELEASE_BIT] = st.release_ok;
				rd_mux[CTRL_LED_SW_BIT] = st.led_sw;
				rd_mux[CTRL_OWNER_LSB +: NPORTS] = st.owner_top;
			end
			OFS_STATUS: rd_mux = status_word;
			OFS_CFG: rd_mux[FILE_W-1:0] = st.file_sel;
			OFS_MPU_CMD:
			begin
				rd_mux[MPU_DW-1:0] = st.mpu_wdata;
				rd_mux[MPU_ADDR_LSB +: MPU_AW] = st.mpu_addr;
				rd_mux[MPU_WRITE_BIT] = st.mpu_write;
				rd_mux[MPU_GO_BIT] = mpu_busy;
			end
			OFS_MPU_DATA: rd_mux[MPU_DW-1:0] = st.mpu_rdata;
			OFS_DECODER:
			begin
				rd_mux[CTRL_W-1:0] = st.dec_ctrl;
				rd_mux[STATUS_IN_LSB +: CTRL_W] = decoder_status_in;
			end
			OFS_OPTICAL:
			begin
				rd_mux[CTRL_W-1:0] = st.opt_ctrl;
				rd_mux[STATUS_IN_LSB +: CTRL_W] = optical_status_in;
			end
			OFS_LED: rd_mux[LED_N-1:0] = st.led_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// LED request order: green, bicolour green, bicolour red
	always_comb
	begin
		led_req = '0;
		led_req[LED_GREEN_N-1:0] = base_led_req_in[LED_GREEN_N-1:0];
		led_req[LED_GREEN_N +: 2] = base_led_req_in[LED_REQ_W-1:LED_GREEN_N];
		led_req[LED_GREEN_N + 2 +: 4] = top_led_req_in[3:0];
		led_req[LED_RED_LSB +: LED_BI_N] = st.led_reg[LED_RED_LSB +: LED_BI_N];
		led_req[LED_N-1] = top_led_req_in[4] | st.led_reg[LED_N-1];
	end

	assign setup_ph = psel_in & ~penable_in;
	assign access_ph = psel_in & penable_in;
	assign mpu_busy = st.mpu_go | (st.mpu_state != MPU_IDLE);

	// Next state of bus, oversight, controller port and pass-through lines
	always_comb
	begin
		next_st = st;
		next_st.phase = ~st.phase;
		next_st.ready = 1'b1;
		next_st.buf_en = st.ready;
		next_st.dtack_on = st.ready & vme_select_in;
		next_st.enable = st.ready & st.release_ok & base_present_in & base_done_in
			& (~top_present_in | top_done_in);
		next_st.auto_load = power_good_in;
		next_st.ga = {ga_backplane_in[3:1], ga_jumper_in, ga_backplane_in[0]};
		next_st.base_tim = {level1_accept_in, bunch_reset_in};
		next_st.top_tim = {level1_accept_in, bunch_reset_in};
		next_st.top_data = decoder_data_in;
		next_st.leds = st.led_sw ? st.led_reg : led_req;
		if (st.recfg_cnt != '0)
			next_st.recfg_cnt = st.recfg_cnt - 1'b1;
		if (setup_ph)
		begin
			next_st.prdata = pwrite_in ? '0 : rd_mux;
			next_st.slverr = ~rd_hit;
		end
		// Controller port steps only where the divided clock falls
		if (st.phase)
		begin
			unique case (st.mpu_state)
				MPU_IDLE:
				begin
					if (st.mpu_go)
					begin
						next_st.mpu_state = MPU_SETUP;
						next_st.mpu_go = 1'b0;
						next_st.port_addr = st.mpu_addr;
						next_st.port_wdata = st.mpu_wdata;
					end
				end
				MPU_SETUP: next_st.mpu_state = MPU_STROBE;
				MPU_STROBE:
				begin
					next_st.mpu_state = MPU_HOLD;
					if (!st.mpu_write)
						next_st.mpu_rdata = mpu_data_in;
				end
				MPU_HOLD: next_st.mpu_state = MPU_IDLE;
			endcase
		end
		if (access_ph && !st.slverr && pwrite_in)
		begin
			unique case (paddr_in)
				OFS_CTRL:
				begin
					next_st.release_ok = pwdata_in[CTRL_RELEASE_BIT];
					next_st.led_sw = pwdata_in[CTRL_LED_SW_BIT];
					next_st.owner_top = pwdata_in[CTRL_OWNER_LSB +: NPORTS];
				end
				OFS_CFG:
				begin
					next_st.file_sel = pwdata_in[FILE_W-1:0];
					if (pwdata_in[CFG_START_BIT])
						next_st.recfg_cnt = RECFG_CW'(RECFG_CYC);
				end
				OFS_MPU_CMD:
				begin
					if (!mpu_busy)
					begin
						next_st.mpu_wdata = pwdata_in[MPU_DW-1:0];
						next_st.mpu_addr = pwdata_in[MPU_ADDR_LSB +: MPU_AW];
						next_st.mpu_write = pwdata_in[MPU_WRITE_BIT];
						if (pwdata_in[MPU_GO_BIT])
							next_st.mpu_go = 1'b1;
					end
				end
				OFS_DECODER: next_st.dec_ctrl = pwdata_in[CTRL_W-1:0];
				OFS_OPTICAL: next_st.opt_ctrl = pwdata_in[CTRL_W-1:0];
				OFS_LED: next_st.led_reg = pwdata_in[LED_N-1:0];
				default: next_st.dec_ctrl = st.dec_ctrl;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			st <= '0;
			st.release_ok <= CTRL_RESET[CTRL_RELEASE_BIT];
			st.mpu_state <= MPU_IDLE;
		end
		else
			st <= next_st;
	end

	// One transceiver switch per IO port
	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++)
		begin : g_port
			port_switch u_port
			(
				.clk_in(clk_in),
				.rstn_in(rstn_in),
				.enable_in(st.enable),
				.owner_top_in(st.owner_top[gi]),
				.base_want_in(base_port_want_in[gi]),
				.base_dir_in(base_port_dir_in[gi]),
				.top_want_in(top_port_want_in[gi]),
				.top_dir_in(top_port_dir_in[gi]),
				.dir_out(port_dir_out[gi]),
				.oe_n_out(port_oe_n_out[gi])
			);
		end
	endgenerate

	// Bus and configuration outputs
	assign prdata_out = st.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = access_ph & st.slverr;
	assign cfg_clk_out = st.phase;
	assign cfg_auto_load_out = st.auto_load;
	assign cfg_file_sel_out = st.file_sel;
	assign cfg_reconfig_out = (st.recfg_cnt != '0);

	// Controller port, strobes follow the access state
	assign mpu_addr_out = st.port_addr;
	assign mpu_data_out = st.port_wdata;
	assign mpu_data_oe_n_out = ~(st.mpu_write && st.mpu_state != MPU_IDLE);
	assign mpu_cs_n_out = (st.mpu_state == MPU_IDLE);
	assign mpu_we_n_out = ~(st.mpu_write && st.mpu_state == MPU_STROBE);
	assign mpu_oe_n_out = ~(!st.mpu_write && st.mpu_state == MPU_STROBE);

	// Bus buffers, oversight and LEDs
	assign vme_buf_en_n_out = ~st.buf_en;
	assign dtack_out = 1'b0;
	assign dtack_oe_n_out = ~st.dtack_on;
	assign enable_out = st.enable;
	assign led_green_out = st.leds[LED_GREEN_N-1:0];
	assign led_bi_green_out = st.leds[LED_GREEN_N +: LED_BI_N];
	assign led_bi_red_out = st.leds[LED_RED_LSB +: LED_BI_N];

	// Address and timing decoder lines
	assign ga_out = st.ga;
	assign decoder_ctrl_out = st.dec_ctrl;
	assign base_bunch_reset_out = st.base_tim[0];
	assign base_level1_accept_out = st.base_tim[1];
	assign top_bunch_reset_out = st.top_tim[0];
	assign top_level1_accept_out = st.top_tim[1];
	assign top_decoder_data_out = st.top_data;
	assign optical_ctrl_out = st.opt_ctrl;
endmodule

/* File: logic/board_support_pkg.sv */
// Purpose: Shared constants for the board support oversight block
// Assumes: 200 MHz system clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned words
package board_support_pkg;
	localparam int NPORTS = 4;
	localparam int DEC_W = 16;
	localparam int GA_W = 7;
	localparam int LED_REQ_W = 5;
	localparam int LED_GREEN_N = 3;
	localparam int LED_BI_N = 6;
	localparam int FILE_W = 3;
	localparam int MPU_AW = 7;
	localparam int MPU_DW = 16;
	localparam int CTRL_W = 8;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CFG = 8'h08;
	localparam logic [7:0] OFS_MPU_CMD = 8'h0C;
	localparam logic [7:0] OFS_MPU_DATA = 8'h10;
	localparam logic [7:0] OFS_DECODER = 8'h14;
	localparam logic [7:0] OFS_OPTICAL = 8'h18;
	localparam logic [7:0] OFS_LED = 8'h1C;

	// Control register fields
	localparam int CTRL_RELEASE_BIT = 0;
	localparam int CTRL_LED_SW_BIT = 1;
	localparam int CTRL_OWNER_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Configuration register fields
	localparam int CFG_START_BIT = 8;
	// Controller port command fields
	localparam int MPU_ADDR_LSB = 16;
	localparam int MPU_WRITE_BIT = 24;
	localparam int MPU_GO_BIT = 31;
	// Status register fields, then status input and red LED field positions
	localparam int ST_BASE_PRES = 0;
	localparam int ST_BASE_DONE = 1;
	localparam int ST_TOP_PRES = 2;
	localparam int ST_TOP_DONE = 3;
	localparam int ST_ENABLE = 4;
	localparam int ST_POWER = 5;
	localparam int ST_MPU_BUSY = 6;
	localparam int ST_RECFG_BUSY = 7;
	localparam int ST_GA_LSB = 8;
	localparam int STATUS_IN_LSB = 8;
	localparam int LED_RED_LSB = 9;

	// Reconfiguration request pulse, least width
	localparam int CLK_PERIOD_PS = 5000;
	localparam int RECFG_PULSE_NS = 1000;
	localparam int RECFG_CYC = (RECFG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RECFG_CW = 8;
endpackage

/* File: logic/port_switch.sv */
// Purpose: Direction and output enable for all transceivers of one IO port
// Assumes: Requests come synchronous to clk_in
// Notes: Direction only changes while the port output is off
module port_switch
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic enable_in,
	input wire logic owner_top_in,
	input wire logic base_want_in,
	input wire logic base_dir_in,
	input wire logic top_want_in,
	input wire logic top_dir_in,
	output logic dir_out,
	output logic oe_n_out
);
	typedef struct packed {
		logic dir;
		logic on;
	} sw_state_t;

	sw_state_t st;
	sw_state_t next_st;
	logic want;
	logic tdir;

	always_comb
	begin
		want = owner_top_in ? top_want_in : base_want_in;
		tdir = owner_top_in ? top_dir_in : base_dir_in;
		next_st = st;
		if (!enable_in)
			next_st.on = 1'b0;
		else if (st.on && (!want || st.dir != tdir))
			next_st.on = 1'b0;
		else if (!st.on && st.dir != tdir)
			next_st.dir = tdir;
		else if (!st.on && want)
			next_st.on = 1'b1;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign dir_out = st.dir;
	assign oe_n_out = ~st.on;
endmodule

/* File: tb/board_support_sva.sv */
// Purpose: Port checks for the board support oversight block
// Assumes: Single clock domain, reset active low
// Notes: Bound by name from the bench top file
module board_support_sva
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic cfg_clk_out,
	input wire logic cfg_auto_load_out,
	input wire logic power_good_in,
	input wire logic mpu_cs_n_out,
	input wire logic mpu_we_n_out,
	input wire logic mpu_oe_n_out,
	input wire logic mpu_data_oe_n_out,
	input wire logic vme_select_in,
	input wire logic vme_buf_en_n_out,
	input wire logic dtack_out,
	input wire logic dtack_oe_n_out,
	input wire logic base_present_in,
	input wire logic base_done_in,
	input wire logic top_present_in,
	input wire logic top_done_in,
	input wire logic enable_out,
	input wire logic [3:0] port_dir_out,
	input wire logic [3:0] port_oe_n_out,
	input wire logic [6:0] ga_out,
	input wire logic [3:0] ga_backplane_in,
	input wire logic [2:0] ga_jumper_in,
	input wire logic level1_accept_in,
	input wire logic base_level1_accept_out,
	input wire logic bunch_reset_in,
	input wire logic top_bunch_reset_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_drop;
		enable_out ##1 !enable_out;
	endsequence
	sequence s_rise;
		!enable_out ##1 enable_out;
	endsequence
	property p_clk_div;
		1 |=> cfg_clk_out != $past(cfg_clk_out);
	endproperty
	property p_mpu_sync;
		$changed(mpu_cs_n_out) |-> $fell(cfg_clk_out);
	endproperty
	property p_buf_off;
		$rose(rstn_in) |-> vme_buf_en_n_out && dtack_oe_n_out;
	endproperty
	property p_dtack;
		!dtack_oe_n_out |-> !dtack_out && $past(vme_select_in);
	endproperty
	property p_hold_off;
		!enable_out |=> &port_oe_n_out;
	endproperty
	property p_release;
		s_rise |-> &port_oe_n_out;
	endproperty
	property p_withdraw;
		s_drop |=> &port_oe_n_out;
	endproperty
	property p_enable;
		enable_out |-> $past(base_present_in && base_done_in && (!top_present_in || top_done_in));
	endproperty
	property p_gap;
		1 |=> &((port_dir_out ~^ $past(port_dir_out)) | (port_oe_n_out & $past(port_oe_n_out)));
	endproperty
	property p_ga;
		1 |=> ga_out == $past({ga_backplane_in[3:1], ga_jumper_in, ga_backplane_in[0]});
	endproperty
	property p_timing;
		1 |=> base_level1_accept_out == $past(level1_accept_in)
			&& top_bunch_reset_out == $past(bunch_reset_in);
	endproperty
	property p_auto;
		1 |=> cfg_auto_load_out == $past(power_good_in);
	endproperty
	property p_strobe;
		!(mpu_we_n_out && mpu_oe_n_out) |-> !mpu_cs_n_out && mpu_we_n_out != mpu_oe_n_out
			&& mpu_data_oe_n_out == mpu_we_n_out;
	endproperty
	a_clk_div: assert property (p_clk_div) else $error("divided clock stuck");
	a_mpu_sync: assert property (p_mpu_sync) else $error("port access off step");
	a_buf_off: assert property (p_buf_off) else $error("buffers on at reset");
	a_dtack: assert property (p_dtack) else $error("stray acknowledge");
	a_hold_off: assert property (p_hold_off) else $error("port on without enable");
	a_release: assert property (p_release) else $error("port on before enable");
	a_withdraw: assert property (p_withdraw) else $error("port kept on after drop");
	a_enable: assert property (p_enable) else $error("enable without status");
	a_gap: assert property (p_gap) else $error("direction turned while on");
	a_ga: assert property (p_ga) else $error("address bits wrong");
	a_timing: assert property (p_timing) else $error("decoder line wrong");
	a_auto: assert property (p_auto) else $error("auto load wrong");
	a_strobe: assert property (p_strobe) else $error("strobe outside access");
endmodule

/* File: tb/fpga_pair_model.sv */
// Purpose: Behavioural pair of main FPGAs facing the block
// Assumes: Configuration takes LOAD_CYC cycles after load is granted
// Notes: Top FPGA asks the inverse direction of the base FPGA
module fpga_pair_model
#(
	parameter int LOAD_CYC = 20
)
(
	input wire logic clk_in,
	input wire logic load_in,
	input wire logic reconfig_in,
	input wire logic top_fit_in,
	input wire logic top_stall_in,
	input wire logic [3:0] want_in,
	input wire logic [3:0] dir_in,
	input wire logic [9:0] led_in,
	output logic base_present_out,
	output logic base_done_out,
	output logic top_present_out,
	output logic top_done_out,
	output logic [3:0] base_want_out,
	output logic [3:0] base_dir_out,
	output logic [3:0] top_want_out,
	output logic [3:0] top_dir_out,
	output logic [4:0] base_led_out,
	output logic [4:0] top_led_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Configuration is lost while reloading
	always @(posedge clk_in)
	begin
		if (!load_in || reconfig_in)
			cnt <= 0;
		else if (cnt < LOAD_CYC)
			cnt <= cnt + 1;
	end
	assign base_present_out = 1'b1;
	assign base_done_out = (cnt == LOAD_CYC);
	assign top_present_out = top_fit_in;
	assign top_done_out = top_fit_in && base_done_out && !top_stall_in;
	assign base_want_out = want_in;
	assign top_want_out = want_in;
	assign base_dir_out = dir_in;
	assign top_dir_out = ~dir_in;
	assign base_led_out = led_in[4:0];
	assign top_led_out = led_in[9:5];
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the board support oversight block
// Assumes: APB answers without wait states
// Notes: FPGA pair model supplies status and requests
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import board_support_pkg::*;
	typedef struct packed {
		logic [3:0] want, dir, own, xdir, gab;
		logic [2:0] gaj;
		logic [6:0] xga;
		logic [9:0] led;
	} row_t;
	row_t rows [4] = '{
		'{4'hF, 4'h5, 4'h0, 4'h5, 4'h9, 3'h5, 7'h4B, 10'h3FF},
		'{4'hF, 4'hC, 4'h3, 4'hF, 4'h6, 3'h2, 7'h34, 10'h155},
		'{4'hA, 4'h0, 4'hF, 4'hF, 4'hF, 3'h7, 7'h7F, 10'h2AA},
		'{4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 3'h0, 7'h00, 10'h000}};
	logic clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, ev;
	logic power_good_in = 0, vme_select_in = 0, bunch_reset_in = 0, level1_accept_in = 0;
	logic top_fit = 1, top_stall = 0;
	logic [7:0] paddr_in = '0, decoder_status_in = 8'h5A, optical_status_in = 8'hA5;
	logic [31:0] pwdata_in = '0, prdata_out, rv;
	logic [15:0] mpu_data_in = 16'hC3E1, decoder_data_in = '0, mpu_data_out, top_decoder_data_out;
	logic [3:0] want = '0, dir = '0, ga_backplane_in = '0, port_dir_out, port_oe_n_out;
	logic [3:0] base_port_want_in, base_port_dir_in, top_port_want_in, top_port_dir_in;
	logic [2:0] ga_jumper_in = '0, cfg_file_sel_out, led_green_out;
	logic [9:0] led = '0;
	logic [6:0] mpu_addr_out, ga_out;
	logic [4:0] base_led_req_in, top_led_req_in;
	logic [5:0] led_bi_green_out, led_bi_red_out;
	logic [7:0] decoder_ctrl_out, optical_ctrl_out;
	logic pready_out, pslverr_out, cfg_clk_out, cfg_auto_load_out, cfg_reconfig_out;
	logic mpu_data_oe_n_out, mpu_cs_n_out, mpu_we_n_out, mpu_oe_n_out, vme_buf_en_n_out;
	logic dtack_out, dtack_oe_n_out, enable_out, base_bunch_reset_out, base_level1_accept_out;
	logic top_bunch_reset_out, top_level1_accept_out;
	logic base_present_in, base_done_in, top_present_in, top_done_in;
	int error_cnt = 0, tests_run = 0;

	board_support_oversight i_board_support_oversight (.clk_in, .rstn_in, .psel_in,
		.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.power_good_in, .cfg_clk_out, .cfg_auto_load_out, .cfg_file_sel_out, .cfg_reconfig_out,
		.mpu_addr_out, .mpu_data_in, .mpu_data_out, .mpu_data_oe_n_out, .mpu_cs_n_out,
		.mpu_we_n_out, .mpu_oe_n_out, .vme_select_in, .vme_buf_en_n_out, .dtack_out,
		.dtack_oe_n_out, .base_present_in, .base_done_in, .top_present_in, .top_done_in,
		.enable_out, .base_port_want_in, .base_port_dir_in, .top_port_want_in, .top_port_dir_in,
		.port_dir_out, .port_oe_n_out, .base_led_req_in, .top_led_req_in, .led_green_out,
		.led_bi_green_out, .led_bi_red_out, .ga_backplane_in, .ga_jumper_in, .ga_out,
		.bunch_reset_in, .level1_accept_in, .decoder_data_in, .decoder_status_in,
		.decoder_ctrl_out, .base_bunch_reset_out, .base_level1_accept_out, .top_bunch_reset_out,
		.top_level1_accept_out, .top_decoder_data_out, .optical_status_in, .optical_ctrl_out);

	fpga_pair_model #(.LOAD_CYC(20)) i_fpga_pair_model (.clk_in, .load_in(cfg_auto_load_out),
		.reconfig_in(cfg_reconfig_out), .top_fit_in(top_fit), .top_stall_in(top_stall),
		.want_in(want), .dir_in(dir), .led_in(led), .base_present_out(base_present_in),
		.base_done_out(base_done_in), .top_present_out(top_present_in),
		.top_done_out(top_done_in), .base_want_out(base_port_want_in),
		.base_dir_out(base_port_dir_in), .top_want_out(top_port_want_in),
		.top_dir_out(top_port_dir_in), .base_led_out(base_led_req_in),
		.top_led_out(top_led_req_in));

	initial
	begin
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	// One APB transfer; read data and error land in rv and ev
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 50);
		chk(pready_out, 1'b1);
		rv = prdata_out;
		ev = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wait_en(input logic v);
		int n = 0;
		while (enable_out !== v && n < 600)
		begin
			@(posedge clk_in);
			n++;
		end
		chk(enable_out, v);
	endtask

	task automatic mpu_wait();
		int n = 0;
		do
		begin
			apb(1'b0, OFS_STATUS, '0);
			n++;
		end
		while (rv[ST_MPU_BUSY] !== 1'b0 && n < 40);
		chk(rv[ST_MPU_BUSY], 1'b0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		report_and_stop();
	end

	initial
	begin
		cyc(5);
		chk(port_oe_n_out, 4'hF);
		chk({vme_buf_en_n_out, dtack_oe_n_out, enable_out}, 3'b110);
		rstn_in <= 1'b1;
		apb(1'b0, OFS_CTRL, '0);
		chk(rv, CTRL_RESET);
		apb(1'b1, 8'h20, 32'hFFFF_FFFF);
		apb(1'b0, 8'h20, '0);
		chk({ev, rv}, 33'h1_0000_0000);
		cyc(30);
		chk({cfg_auto_load_out, enable_out}, 2'b00);
		power_good_in <= 1'b1;
		wait_en(1'b1);
		chk(cfg_auto_load_out, 1'b1);
		$display("power up done");
		foreach (rows[i])
		begin
			want <= rows[i].want;
			dir <= rows[i].dir;
			led <= rows[i].led;
			ga_backplane_in <= rows[i].gab;
			ga_jumper_in <= rows[i].gaj;
			level1_accept_in <= i[0];
			bunch_reset_in <= i[1];
			decoder_data_in <= {4{rows[i].want}};
			apb(1'b1, OFS_CTRL, {20'h0, rows[i].own, 8'h01});
			cyc(6);
			chk(port_oe_n_out ^ rows[i].want, 4'hF);
			chk(port_dir_out & rows[i].want, rows[i].xdir & rows[i].want);
			chk({led_bi_red_out, led_bi_green_out, led_green_out}, {led[9], 5'h0, led[8:0]});
			chk(ga_out, rows[i].xga);
			chk({top_decoder_data_out, base_bunch_reset_out, base_level1_accept_out,
				top_bunch_reset_out, top_level1_accept_out}, {{4{rows[i].want}}, i[1], i[0], i[1], i[0]});
			$display("row %0d done", i);
		end
		for (int k = 0; k < 2; k++)
		begin
			apb(1'b1, OFS_DECODER + 8'(4 * k), 32'h3C + k);
			apb(1'b0, OFS_DECODER + 8'(4 * k), '0);
			chk(rv[15:8], k ? optical_status_in : decoder_status_in);
		end
		chk({optical_ctrl_out, decoder_ctrl_out}, 16'h3D3C);
		apb(1'b1, OFS_MPU_CMD, 32'h8115_1234);
		mpu_wait();
		chk(mpu_data_out, 16'h1234);
		apb(1'b1, OFS_MPU_CMD, 32'h8015_0000);
		mpu_wait();
		apb(1'b0, OFS_MPU_DATA, '0);
		chk({rv, mpu_addr_out}, {16'h0, mpu_data_in, 7'h15});
		$display("controller port done");
		want <= 4'hF;
		apb(1'b1, OFS_CFG, 32'h0000_0105);
		cyc(2);
		chk({cfg_reconfig_out, cfg_file_sel_out}, 4'hD);
		wait_en(1'b0);
		cyc(2);
		chk(port_oe_n_out, 4'hF);
		wait_en(1'b1);
		top_stall <= 1'b1;
		wait_en(1'b0);
		top_stall <= 1'b0;
		wait_en(1'b1);
		vme_select_in <= 1'b1;
		cyc(3);
		chk({vme_buf_en_n_out, dtack_oe_n_out, dtack_out}, 3'b000);
		vme_select_in <= 1'b0;
		cyc(3);
		chk(dtack_oe_n_out, 1'b1);
		apb(1'b1, OFS_LED, 32'h0000_7E00);
		cyc(2);
		chk(led_bi_red_out, 6'h3F);
		apb(1'b1, OFS_CTRL, 32'h0000_0003);
		cyc(2);
		chk({led_bi_red_out, led_bi_green_out, led_green_out}, 15'h7E00);
		$display("led register done");
		apb(1'b1, OFS_CTRL, '0);
		wait_en(1'b0);
		cyc(2);
		chk(port_oe_n_out, 4'hF);
		$display("oversight done");
		report_and_stop();
	end
endmodule

bind board_support_oversight board_support_sva i_board_support_sva (.clk_in, .rstn_in,
	.cfg_clk_out, .cfg_auto_load_out, .power_good_in, .mpu_cs_n_out, .vme_select_in,
	.mpu_we_n_out, .mpu_oe_n_out, .mpu_data_oe_n_out,
	.vme_buf_en_n_out, .dtack_out, .dtack_oe_n_out, .base_present_in, .base_done_in,
	.top_present_in, .top_done_in, .enable_out, .port_dir_out, .port_oe_n_out, .ga_out,
	.ga_backplane_in, .ga_jumper_in, .level1_accept_in, .base_level1_accept_out,
	.bunch_reset_in, .top_bunch_reset_out);
